// [hw/odd_regs.svh]
`ifndef ODD_REGS_SVH
`define ODD_REGS_SVH

// register byte addresses on the configuration port
`define ODD_ADDR_DRIVER_CONFIG 8'h4e
`define ODD_ADDR_MODE_SELECT 8'h4f
`define ODD_ADDR_DIV_HIGH 8'h50
`define ODD_ADDR_DIV_MID 8'h51
`define ODD_ADDR_DIV_LOW 8'h52
`define ODD_ADDR_PHASE_STRENGTH 8'h53
`define ODD_ADDR_DELAY_SETTING 8'h54
`define ODD_ADDR_SUPPLY_SETTING 8'h55

`define ODD_RESET_VALUE 8'h00

// field positions
`define ODD_DRV_STD_MSB 2
`define ODD_DRV_STD_LSB 0
`define ODD_DIV_TOP_MSB 7
`define ODD_DIV_TOP_LSB 6
`define ODD_FINE_EXT_BIT 4
`define ODD_MODE_MSB 3
`define ODD_MODE_LSB 0
`define ODD_DIV_HIGH_MSB 3
`define ODD_DIV_HIGH_LSB 0
`define ODD_PHASE_MSB 7
`define ODD_PHASE_LSB 6
`define ODD_STRENGTH_MSB 2
`define ODD_STRENGTH_LSB 0
`define ODD_COARSE_MSB 5
`define ODD_COARSE_LSB 0
`define ODD_FINE_MSB 7
`define ODD_FINE_LSB 6
`define ODD_SUPPLY_MSB 4
`define ODD_SUPPLY_LSB 3

// fine delay timing
`define ODD_FINE_STEP_PS 8'd30
`define ODD_FINE_MAX_STEPS 3'd4

`endif

// [hw/odd_pkg.sv]
`default_nettype none
package odd_pkg;

    typedef enum logic [2:0] {
        ODD_DRV_LVDS,
        ODD_DRV_LVPECL_CM,
        ODD_DRV_CML,
        ODD_DRV_HCSL,
        ODD_DRV_LVDS_BOOST,
        ODD_DRV_LVPECL_NOCM,
        ODD_DRV_INVALID
    } odd_driver_standard_e;

    typedef enum logic [1:0] {
        ODD_SUPPLY_1V8,
        ODD_SUPPLY_2V5,
        ODD_SUPPLY_3V3,
        ODD_SUPPLY_INVALID
    } odd_supply_level_e;

    typedef enum logic [2:0] {
        ODD_TERM_EXTERNAL,
        ODD_TERM_PULL_UP,
        ODD_TERM_PULL_DOWN,
        ODD_TERM_CMOS_SINGLE,
        ODD_TERM_INVALID
    } odd_termination_e;

    // one access on the configuration port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } odd_reg_req_s;

    // settings handed to the output driver
    typedef struct packed {
        logic [31:0] output_divide_ratio;
        logic [5:0] coarse_delay;
        logic [2:0] fine_delay_steps;
        logic [7:0] fine_delay_ps;
        odd_driver_standard_e driver_standard_select;
        odd_supply_level_e output_supply_level;
        odd_termination_e termination;
        logic positive_leg_cmos;
        logic negative_leg_cmos;
        logic [1:0] phase_select;
        logic [2:0] drive_strength;
        logic config_invalid;
    } odd_driver_cfg_s;

    typedef struct packed {
        logic [7:0] driver_config;
        logic [7:0] mode_select;
        logic [7:0] div_high;
        logic [7:0] div_mid;
        logic [7:0] div_low;
        logic [7:0] phase_strength;
        logic [7:0] delay_setting;
        logic [7:0] supply_setting;
        logic [7:0] rdata;
        logic rvalid;
        odd_driver_cfg_s cfg;
    } odd_state_s;

endpackage : odd_pkg
`default_nettype wire

// [hw/odd_output_channel.sv]
`timescale 1ns/10ps
`default_nettype none
`include "odd_regs.svh"

module odd_output_channel
    import odd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire odd_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output var odd_driver_cfg_s driver_cfg_o
);

    // registers, read answer and decoded setting share one flop image
    odd_state_s state_q;
    odd_state_s state_d;

    function automatic logic [7:0] read_mux(input odd_state_s s,
                                            input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `ODD_ADDR_DRIVER_CONFIG: v = s.driver_config;
            `ODD_ADDR_MODE_SELECT: v = s.mode_select;
            `ODD_ADDR_DIV_HIGH: v = s.div_high;
            `ODD_ADDR_DIV_MID: v = s.div_mid;
            `ODD_ADDR_DIV_LOW: v = s.div_low;
            `ODD_ADDR_PHASE_STRENGTH: v = s.phase_strength;
            `ODD_ADDR_DELAY_SETTING: v = s.delay_setting;
            `ODD_ADDR_SUPPLY_SETTING: v = s.supply_setting;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    // register layout as software sees it:
    //   driver config: 7:6 divide 31:30, 4 fine extension, 2:0 standard
    //   mode select: 3:0 termination and cmos legs
    //   divide high: 3:0 divide 19:16, 7:4 spare
    //   divide mid and low: divide 15:8 and 7:0
    //   phase and strength: 7:6 cmos phase, 2:0 drive strength
    //   delay setting: 7:6 fine code, 5:0 coarse periods
    //   supply setting: 4:3 supply level
    function automatic logic [31:0] decode_ratio(input odd_state_s s);
        logic [31:0] r;
        r = '0;
        r[31:30] = s.driver_config[`ODD_DIV_TOP_MSB:`ODD_DIV_TOP_LSB];
        r[19:16] = s.div_high[`ODD_DIV_HIGH_MSB:`ODD_DIV_HIGH_LSB];
        r[15:8] = s.div_mid;
        r[7:0] = s.div_low;
        return r;
    endfunction : decode_ratio

    // three-bit fine code: the extension bit sits above the delay pair
    function automatic logic [2:0] fine_code(input odd_state_s s);
        return {s.driver_config[`ODD_FINE_EXT_BIT],
                s.delay_setting[`ODD_FINE_MSB:`ODD_FINE_LSB]};
    endfunction : fine_code

    // codes above four are clamped: the delay line stops at four steps
    function automatic logic [2:0] fine_steps(input logic [2:0] code);
        logic [2:0] n;
        n = code;
        if (code > `ODD_FINE_MAX_STEPS) begin
            n = `ODD_FINE_MAX_STEPS;
        end
        return n;
    endfunction : fine_steps

    // codes six and seven name no standard
    function automatic odd_driver_standard_e decode_standard(
        input logic [2:0] code);
        odd_driver_standard_e e;
        e = ODD_DRV_INVALID;
        if (code <= 3'h5) begin
            e = odd_driver_standard_e'(code);
        end
        return e;
    endfunction : decode_standard

    // code 11 names no level and maps onto the invalid member
    function automatic odd_supply_level_e decode_supply(
        input logic [1:0] code);
        return odd_supply_level_e'(code);
    endfunction : decode_supply

    // whole driver setting; the invalid flag gathers every undefined code
    function automatic odd_driver_cfg_s decode_cfg(input odd_state_s s);
        odd_driver_cfg_s cfg;
        logic [2:0] fine;
        logic [2:0] drv;
        logic [1:0] supply;
        logic [3:0] mode;
        logic mode_bad;
        cfg = '0;
        cfg.output_divide_ratio = decode_ratio(s);
        cfg.coarse_delay =
            s.delay_setting[`ODD_COARSE_MSB:`ODD_COARSE_LSB];

        fine = fine_code(s);
        cfg.fine_delay_steps = fine_steps(fine);
        cfg.fine_delay_ps =
            8'(cfg.fine_delay_steps * `ODD_FINE_STEP_PS);

        drv = s.driver_config[`ODD_DRV_STD_MSB:`ODD_DRV_STD_LSB];
        cfg.driver_standard_select = decode_standard(drv);

        supply = s.supply_setting[`ODD_SUPPLY_MSB:`ODD_SUPPLY_LSB];
        cfg.output_supply_level = decode_supply(supply);

        mode = s.mode_select[`ODD_MODE_MSB:`ODD_MODE_LSB];
        mode_bad = 1'b0;
        case (mode)
            4'h0: begin
                cfg.termination = ODD_TERM_EXTERNAL;
            end
            4'h2: begin
                cfg.termination = ODD_TERM_PULL_UP;
            end
            4'h1: begin
                cfg.termination = ODD_TERM_PULL_DOWN;
            end
            4'h4: begin
                cfg.termination = ODD_TERM_CMOS_SINGLE;
                cfg.positive_leg_cmos = 1'b1;
            end
            4'h8: begin
                cfg.termination = ODD_TERM_CMOS_SINGLE;
                cfg.negative_leg_cmos = 1'b1;
            end
            4'hc: begin
                cfg.termination = ODD_TERM_CMOS_SINGLE;
                cfg.positive_leg_cmos = 1'b1;
                cfg.negative_leg_cmos = 1'b1;
            end
            // any other pattern leaves both legs off and flags the setting
            default: begin
                cfg.termination = ODD_TERM_INVALID;
                mode_bad = 1'b1;
            end
        endcase

        cfg.phase_select = s.phase_strength[`ODD_PHASE_MSB:`ODD_PHASE_LSB];
        // strength passes as written; all ones is software's choice
        cfg.drive_strength =
            s.phase_strength[`ODD_STRENGTH_MSB:`ODD_STRENGTH_LSB];
        cfg.config_invalid = (drv > 3'h5) | (supply == 2'h3) | mode_bad |
                             (fine > `ODD_FINE_MAX_STEPS);
        return cfg;
    endfunction : decode_cfg

    // one access per cycle; a read beside a write sees the old byte
    always_comb begin
        state_d = state_q;
        state_d.rvalid = reg_req_i.rd;
        if (reg_req_i.rd) begin
            state_d.rdata = read_mux(state_q, reg_req_i.addr);
        end
        // full bytes are kept, spare bits included, so reads echo writes
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `ODD_ADDR_DRIVER_CONFIG: begin
                    state_d.driver_config = reg_req_i.wdata;
                end
                `ODD_ADDR_MODE_SELECT: begin
                    state_d.mode_select = reg_req_i.wdata;
                end
                `ODD_ADDR_DIV_HIGH: begin
                    state_d.div_high = reg_req_i.wdata;
                end
                `ODD_ADDR_DIV_MID: begin
                    state_d.div_mid = reg_req_i.wdata;
                end
                `ODD_ADDR_DIV_LOW: begin
                    state_d.div_low = reg_req_i.wdata;
                end
                `ODD_ADDR_PHASE_STRENGTH: begin
                    state_d.phase_strength = reg_req_i.wdata;
                end
                `ODD_ADDR_DELAY_SETTING: begin
                    state_d.delay_setting = reg_req_i.wdata;
                end
                `ODD_ADDR_SUPPLY_SETTING: begin
                    state_d.supply_setting = reg_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
        // decode the next image so the output flops follow each write
        state_d.cfg = decode_cfg(state_d);
    end

    // all-zero registers decode to an all-zero setting
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // read data holds until the next read; valid pulses for one cycle
    assign reg_rdata_o = state_q.rdata;
    assign reg_rvalid_o = state_q.rvalid;
    // the driver sees flops, not the decode cone, and still no extra latency
    assign driver_cfg_o = state_q.cfg;

endmodule : odd_output_channel
`default_nettype wire

// [verification/odd_output_channel_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module odd_output_channel_asserts
    import odd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire odd_reg_req_s reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire odd_driver_cfg_s driver_cfg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    odd_driver_cfg_s c;
    assign w = reg_req_i.wr;
    assign a = reg_req_i.addr;
    assign d = reg_req_i.wdata;
    assign c = driver_cfg_o;
    rd_answer_a: assert property (reg_req_i.rd |=> reg_rvalid_o)
        else $error("read not answered");
    no_rd_quiet_a: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
        else $error("answer without read");
    div_high_a: assert property (w && a == 8'h50
        |=> c.output_divide_ratio[19:16] == $past(d[3:0]))
        else $error("divide bits 19:16 wrong");
    div_mid_a: assert property (w && a == 8'h51
        |=> c.output_divide_ratio[15:8] == $past(d))
        else $error("divide bits 15:8 wrong");
    div_top_a: assert property (w && a == 8'h4e
        |=> c.output_divide_ratio[31:30] == $past(d[7:6]))
        else $error("divide bits 31:30 wrong");
    coarse_delay_a: assert property (w && a == 8'h54
        |=> c.coarse_delay == $past(d[5:0]))
        else $error("coarse delay wrong");
    fine_ps_a: assert property (
        c.fine_delay_ps == c.fine_delay_steps * 8'd30)
        else $error("fine delay not steps of 30");
    drv_std_a: assert property (w && a == 8'h4e && d[2:0] < 3'd6
        |=> c.driver_standard_select == $past(d[2:0]))
        else $error("driver standard wrong");
    supply_lvl_a: assert property (w && a == 8'h55
        |=> c.output_supply_level == $past(d[4:3]))
        else $error("supply level wrong");
    read_back_a: assert property (reg_req_i.rd && !w && a == 8'h51
        |=> reg_rdata_o == c.output_divide_ratio[15:8])
        else $error("read back differs");
    cmos_legs_a: assert property (w && a == 8'h4f && d[3:0] == 4'hc
        |=> c.positive_leg_cmos && c.negative_leg_cmos)
        else $error("cmos legs not both on");
    cover property (reg_req_i.rd ##1 reg_rvalid_o);
    cover property (w && a == 8'h4e && d[4]);
    cover property (c.config_invalid);
    cover property (w && a == 8'h4f && d[3:0] == 4'hc);
endmodule : odd_output_channel_asserts
bind odd_output_channel odd_output_channel_asserts chk_u (.clk_i(clk_i),
    .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .driver_cfg_o(driver_cfg_o));
`default_nettype wire

// [verification/odd_output_channel_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module odd_output_channel_bench import odd_pkg::*;;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    odd_reg_req_s req = '0;
    logic [7:0] rdata;
    logic rvalid;
    odd_driver_cfg_s cfg;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    odd_output_channel dut_u (.clk_i(clk_i), .reset_i(reset_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .driver_cfg_o(cfg));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b0, a, d};
    endtask : wr
    // releases the port, then waits for the last access to settle
    task automatic idle;
        @(posedge clk_i);
        req <= '0;
        @(negedge clk_i);
    endtask : idle
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_i);
        req <= '{1'b0, 1'b1, a, 8'h00};
        idle();
        chk("rvalid", rvalid, 1);
        chk("rdata", rdata, e);
    endtask : rd
    task automatic t_div;
        wr(8'h50, 8'hf5);
        wr(8'h51, 8'hab);
        wr(8'h52, 8'hcd);
        wr(8'h4e, 8'hc0);
        wr(8'h56, 8'hff);
        idle();
        chk("ratio", cfg.output_divide_ratio, 32'hc005abcd);
        rd(8'h50, 8'hf5);
        rd(8'h56, 8'h00);
        $display("divider test done");
    endtask : t_div
    task automatic t_delay;
        int s;
        for (int f = 0; f < 8; f++) begin
            wr(8'h4e, {3'b000, f[2], 4'h0});
            wr(8'h54, {f[1:0], 6'(63 - f)});
            idle();
            s = (f > 4) ? 4 : f;
            chk("coarse", cfg.coarse_delay, 63 - f);
            chk("steps", cfg.fine_delay_steps, s);
            chk("fine ps", cfg.fine_delay_ps, s * 30);
            chk("fine bad", cfg.config_invalid, f > 4);
        end
        $display("delay test done");
    endtask : t_delay
    task automatic t_fields;
        logic [3:0] m [7] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc, 4'h3};
        int t [7] = '{0, 1, 2, 3, 3, 3, 4};
        for (int c = 0; c < 8; c++) begin
            wr(8'h4e, 8'(c));
            wr(8'h55, 8'((c % 4) << 3));
            idle();
            chk("standard", cfg.driver_standard_select, c > 5 ? 6 : c);
            chk("supply", cfg.output_supply_level, c % 4);
            chk("bad", cfg.config_invalid, c > 5 || c % 4 == 3);
        end
        for (int i = 0; i < 7; i++) begin
            wr(8'h4f, {4'h0, m[i]});
            idle();
            chk("p leg", cfg.positive_leg_cmos, m[i][2]);
            chk("n leg", cfg.negative_leg_cmos, m[i][3]);
            chk("term", cfg.termination, t[i]);
        end
        wr(8'h53, 8'hc7);
        idle();
        chk("strength", cfg.drive_strength, 7);
        chk("phase", cfg.phase_select, 3);
        $display("field test done");
    endtask : t_fields
    task automatic t_reset;
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(negedge clk_i);
        chk("mid reset cfg", cfg === '0, 1);
        chk("mid reset rvalid", rvalid, 0);
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd(8'h51, 8'h00);
        rd(8'h4e, 8'h00);
        $display("mid-run reset test done");
    endtask : t_reset
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        chk("cfg zero", cfg === '0, 1);
        for (int i = 8'h4e; i < 8'h56; i++) rd(8'(i), 8'h00);
        $display("reset test done");
        t_div();
        t_delay();
        t_fields();
        t_reset();
        end_of_test();
    end
endmodule : odd_output_channel_bench
`default_nettype wire
